// ==== lshab_defines.svh ====
// constants for the lin slave header receiver with automatic bit rate
`ifndef LSHAB_DEFINES_SVH
`define LSHAB_DEFINES_SVH

`define LSHAB_CNT_W 20
`define LSHAB_CLK_HZ 25000000
`define LSHAB_MAX_BPS 20000
`define LSHAB_NOM_BIT_CYC (`LSHAB_CLK_HZ / `LSHAB_MAX_BPS)
`define LSHAB_BREAK_BITS 11
`define LSHAB_SYNC_TIMEOUT_CYC 250000
`define LSHAB_SYNC_FALLS 3'h4
`define LSHAB_PERIOD_SHIFT 3
`define LSHAB_HALF_SHIFT 1
`define LSHAB_LAST_BIT 4'h9
`define LSHAB_FIRST_DATA_BIT 4'h1
`define LSHAB_ID_LAST_SIGNAL 6'h3B
`define LSHAB_ID_DIAG_HI 6'h3D
`define LSHAB_ID_USER 6'h3E
`define LSHAB_ID_MSB 5
`define LSHAB_PAR_LSB 6

`endif

// ==== lshab_pkg.sv ====
// types for the lin slave header receiver
`include "lshab_defines.svh"
package lshab_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_DELIM     = 3'b001,
        ST_SYNC_WAIT = 3'b010,
        ST_SYNC_MEAS = 3'b011,
        ST_PID_WAIT  = 3'b100,
        ST_PID_RX    = 3'b101
    } lshab_state_t;

    typedef enum logic [1:0] {
        CLS_SIGNAL = 2'b00,
        CLS_DIAG   = 2'b01,
        CLS_USER   = 2'b10,
        CLS_RSVD   = 2'b11
    } lshab_class_t;

    typedef logic [`LSHAB_CNT_W-1:0] lshab_cnt_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic rx_prev;
        lshab_state_t state;
        lshab_cnt_t low_cnt;
        lshab_cnt_t meas_cnt;
        logic [2:0] fall_cnt;
        lshab_cnt_t bit_period;
        logic period_valid;
        logic [7:0] shift;
        logic [3:0] bit_idx;
        logic frame_start;
        logic pid_valid;
        logic [5:0] ident;
        logic [1:0] parity;
        logic parity_err;
        lshab_class_t id_class;
        logic sync_err;
        logic frame_err;
    } lshab_regs_t;

    typedef struct packed {
        lshab_cnt_t cnt;
        logic tick;
    } lshab_bg_regs_t;

endpackage

// ==== lshab_baudgen.sv ====
// bit-rate generator: mid-bit sample pulses at the measured bit period
`timescale 1ns/1ps
`include "lshab_defines.svh"
module lshab_baudgen (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire lshab_pkg::lshab_cnt_t period,
    input wire logic restart,
    input wire logic run,
    // sample strobe
    output logic sample_en
);
    import lshab_pkg::*;

    lshab_bg_regs_t r_q, r_d;

    always_comb begin
        r_d = r_q;
        r_d.tick = 1'b0;
        if (restart) begin
            // first sample lands mid start bit
            r_d.cnt = period >> `LSHAB_HALF_SHIFT;
        end else if (run) begin
            if (r_q.cnt == '0) begin
                r_d.tick = 1'b1;
                r_d.cnt = period - lshab_cnt_t'(1);
            end else begin
                r_d.cnt = r_q.cnt - lshab_cnt_t'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign sample_en = r_q.tick;
endmodule

// ==== lshab_header_rx.sv ====
// lin slave header receiver: break detect, synch measurement, identifier decode
//
// Contract
// - frame is break plus 4..11 bytes; any break restarts header reception
// - break recognised after 11 nominal bit times of low bus
// - count clocks from synch start edge to fourth following falling edge
// - bit period is synch interval shifted right by three
// - derived bit period loaded into bit-rate generator for the identifier byte
// - byte after synch is identifier: bits 0-5 id, 6-7 parity
// - classify id: up to 3B signal, 3C-3D diagnostic, 3E user, 3F reserved
// - bus rates up to 20 kbit/s supported
`timescale 1ns/1ps
`include "lshab_defines.svh"
module lshab_header_rx #(
    parameter int BREAK_CYCLES = `LSHAB_BREAK_BITS * `LSHAB_NOM_BIT_CYC,
    parameter int SYNC_TIMEOUT = `LSHAB_SYNC_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // bus pin
    input wire logic lin_rx,
    // frame events
    output logic frame_start,
    output logic sync_err,
    output logic frame_err,
    // recovered rate
    output lshab_pkg::lshab_cnt_t bit_period,
    output logic period_valid,
    // identifier
    output logic pid_valid,
    output logic [5:0] ident,
    output logic [1:0] parity,
    output logic parity_err,
    output lshab_pkg::lshab_class_t id_class
);
    import lshab_pkg::*;

    localparam lshab_cnt_t BREAK_LAST = lshab_cnt_t'(BREAK_CYCLES - 1);
    localparam lshab_cnt_t TIMEOUT_LAST = lshab_cnt_t'(SYNC_TIMEOUT - 1);
    localparam lshab_cnt_t MIN_PERIOD = lshab_cnt_t'(`LSHAB_NOM_BIT_CYC);

    lshab_regs_t r_q, r_d;
    logic bg_restart;
    logic bg_run;
    logic sample_en;

    function automatic logic [1:0] pid_parity(input logic [5:0] id);
        pid_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                      id[0] ^ id[1] ^ id[2] ^ id[4]};
    endfunction

    function automatic lshab_class_t id_category(input logic [5:0] id);
        if (id <= `LSHAB_ID_LAST_SIGNAL) begin
            id_category = CLS_SIGNAL;
        end else if (id <= `LSHAB_ID_DIAG_HI) begin
            id_category = CLS_DIAG;
        end else if (id == `LSHAB_ID_USER) begin
            id_category = CLS_USER;
        end else begin
            id_category = CLS_RSVD;
        end
    endfunction

    function automatic lshab_cnt_t cnt_inc(input lshab_cnt_t c);
        cnt_inc = c + lshab_cnt_t'(1);
    endfunction

    lshab_baudgen u_baudgen (
        .mclk(mclk),
        .reset_n(reset_n),
        .period(r_q.bit_period),
        .restart(bg_restart),
        .run(bg_run),
        .sample_en(sample_en)
    );

    logic rx;
    logic fall;
    logic [5:0] rx_id;
    assign rx = r_q.sync2;
    assign fall = r_q.rx_prev & ~r_q.sync2;
    assign rx_id = r_q.shift[`LSHAB_ID_MSB:0];

    always_comb begin
        r_d = r_q;
        bg_restart = 1'b0;
        bg_run = 1'b0;
        r_d.frame_start = 1'b0;
        r_d.pid_valid = 1'b0;
        r_d.sync_err = 1'b0;
        r_d.frame_err = 1'b0;
        // two-stage synchroniser, pin is asynchronous
        r_d.sync1 = lin_rx;
        r_d.sync2 = r_q.sync1;
        r_d.rx_prev = r_q.sync2;

        // low-run counter runs in every state so a break always wins
        if (rx) begin
            r_d.low_cnt = '0;
        end else if (r_q.low_cnt != BREAK_LAST) begin
            r_d.low_cnt = cnt_inc(r_q.low_cnt);
        end

        unique case (r_q.state)
            ST_IDLE: begin
                // nothing until the master breaks
            end
            ST_DELIM: begin
                if (rx) begin // delimiter seen
                    r_d.state = ST_SYNC_WAIT;
                    r_d.meas_cnt = '0;
                end
            end
            ST_SYNC_WAIT, ST_SYNC_MEAS: begin
                r_d.meas_cnt = cnt_inc(r_q.meas_cnt);
                if (fall && r_q.state == ST_SYNC_WAIT) begin
                    // synch start bit edge opens the window
                    r_d.state = ST_SYNC_MEAS;
                    r_d.meas_cnt = lshab_cnt_t'(1);
                    r_d.fall_cnt = '0;
                end else if (fall) begin
                    r_d.fall_cnt = r_q.fall_cnt + 3'h1;
                    if (r_d.fall_cnt == `LSHAB_SYNC_FALLS) begin
                        // eight bit times measured
                        // bit_period kept on a rate error, period_valid marks it unusable
                        r_d.bit_period = r_q.meas_cnt >> `LSHAB_PERIOD_SHIFT;
                        if (r_d.bit_period < MIN_PERIOD) begin
                            // faster than the bus allows
                            r_d.sync_err = 1'b1;
                            r_d.period_valid = 1'b0;
                            r_d.state = ST_IDLE;
                        end else begin
                            r_d.period_valid = 1'b1;
                            r_d.state = ST_PID_WAIT;
                            r_d.meas_cnt = '0;
                        end
                    end
                end else if (r_q.meas_cnt == TIMEOUT_LAST) begin
                    r_d.sync_err = 1'b1;
                    r_d.state = ST_IDLE;
                end
            end
            ST_PID_WAIT: begin
                r_d.meas_cnt = cnt_inc(r_q.meas_cnt);
                if (fall) begin
                    // resync generator on identifier start bit
                    bg_restart = 1'b1;
                    r_d.bit_idx = '0;
                    r_d.state = ST_PID_RX;
                end else if (r_q.meas_cnt == TIMEOUT_LAST) begin
                    // identifier never started, header dropped
                    r_d.frame_err = 1'b1;
                    r_d.state = ST_IDLE;
                end
            end
            ST_PID_RX: begin
                bg_run = 1'b1;
                if (sample_en) begin
                    r_d.bit_idx = r_q.bit_idx + 4'h1;
                    if (r_q.bit_idx == '0 && rx) begin
                        // glitch, not a start bit
                        r_d.state = ST_PID_WAIT;
                    end else if (r_q.bit_idx >= `LSHAB_FIRST_DATA_BIT &&
                                 r_q.bit_idx < `LSHAB_LAST_BIT) begin
                        r_d.shift = {rx, r_q.shift[7:1]}; // lsb first
                    end else if (r_q.bit_idx == `LSHAB_LAST_BIT) begin
                        r_d.state = ST_IDLE;
                        if (!rx) begin
                            r_d.frame_err = 1'b1; // missing stop bit
                        end else begin
                            r_d.pid_valid = 1'b1;
                            r_d.ident = rx_id;
                            r_d.parity = r_q.shift[7:`LSHAB_PAR_LSB];
                            r_d.parity_err = pid_parity(rx_id)
                                != r_q.shift[7:`LSHAB_PAR_LSB];
                            r_d.id_class =
                                id_category(rx_id);
                        end
                    end
                end
            end
            default: begin
                r_d.state = ST_IDLE;
            end
        endcase

        // break threshold, not full length, so a fast master still counts
        if (!rx && r_q.low_cnt == BREAK_LAST - lshab_cnt_t'(1)) begin
            r_d.frame_start = 1'b1;
            r_d.state = ST_DELIM; // a break aborts whatever was running
            r_d.period_valid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign frame_start = r_q.frame_start;
    assign sync_err = r_q.sync_err;
    assign frame_err = r_q.frame_err;
    assign bit_period = r_q.bit_period;
    assign period_valid = r_q.period_valid;
    assign pid_valid = r_q.pid_valid;
    assign ident = r_q.ident;
    assign parity = r_q.parity;
    assign parity_err = r_q.parity_err;
    assign id_class = r_q.id_class;
endmodule

// ==== lshab_header_rx_props.sv ====
// assertion checker for the lin slave header receiver
`timescale 1ns/1ps
`include "lshab_defines.svh"
module lshab_header_rx_props #(
    parameter int BREAK_CYCLES = 13750
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // bus and events
    input wire logic lin_rx,
    input wire logic frame_start,
    input wire logic sync_err,
    input wire logic frame_err,
    // rate and identifier
    input wire lshab_pkg::lshab_cnt_t bit_period,
    input wire logic period_valid,
    input wire logic pid_valid,
    input wire logic [5:0] ident,
    input wire logic [1:0] parity,
    input wire logic parity_err,
    input wire lshab_pkg::lshab_class_t id_class
);
    import lshab_pkg::*;
    logic [19:0] low_run_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // low run at the pin, so synchroniser slips show up
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_run_q <= 20'h0;
        end else begin
            low_run_q <= lin_rx ? 20'h0 : low_run_q + 20'h1;
        end
    end
    a_break_low_len: assert property (
        frame_start |-> low_run_q >= BREAK_CYCLES - 2 && low_run_q <= BREAK_CYCLES + 4)
        else $error("break flagged at wrong low length");
    a_break_drops_rate: assert property (frame_start |=> !period_valid)
        else $error("rate kept across a break");
    a_pid_one_cycle: assert property (pid_valid |=> !pid_valid)
        else $error("identifier strobe too long");
    a_pid_needs_rate: assert property (pid_valid |-> period_valid)
        else $error("identifier without measured rate");
    a_rate_in_range: assert property (
        period_valid |-> bit_period >= `LSHAB_NOM_BIT_CYC)
        else $error("rate above limit accepted");
    a_id_class_map: assert property (pid_valid |-> id_class == (ident <= 6'h3B ? CLS_SIGNAL :
        ident == 6'h3E ? CLS_USER : ident == 6'h3F ? CLS_RSVD : CLS_DIAG))
        else $error("identifier class wrong");
    a_id_parity_chk: assert property (pid_valid |-> parity_err == (parity !=
        {~^{ident[1], ident[3], ident[4], ident[5]}, ^{ident[0], ident[1], ident[2], ident[4]}}))
        else $error("parity flag wrong");
    a_id_held: assert property ($changed(ident) |-> pid_valid)
        else $error("identifier changed without strobe");
    a_sync_err_pulse: assert property (sync_err |=> !sync_err)
        else $error("synch error strobe too long");
    c_break: cover property (frame_start);
    c_bad_parity: cover property (pid_valid && parity_err);
    c_sync_timeout: cover property (sync_err);
endmodule

bind lshab_header_rx lshab_header_rx_props #(.BREAK_CYCLES(BREAK_CYCLES)) lshab_header_rx_props_inst (
    .mclk(mclk), .reset_n(reset_n), .lin_rx(lin_rx), .frame_start(frame_start),
    .sync_err(sync_err), .frame_err(frame_err), .bit_period(bit_period),
    .period_valid(period_valid), .pid_valid(pid_valid), .ident(ident), .parity(parity),
    .parity_err(parity_err), .id_class(id_class));

// ==== lshab_lin_master.sv ====
// lin master model driving the single-wire bus
`timescale 1ns/1ps
module lshab_lin_master (
    // clock
    input wire logic mclk,
    // bus, recessive high through the pull-up
    output logic lin_rx
);
    initial begin
        lin_rx = 1'b1;
    end
    // called just after a falling edge; level held n cycles
    task automatic hold(input logic lvl, input int n);
        lin_rx = lvl;
        repeat (n) @(negedge mclk);
    endtask
    task automatic send_byte(input logic [7:0] b, input int bit_cyc);
        hold(1'b0, bit_cyc);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], bit_cyc);
        end
        hold(1'b1, bit_cyc);
    endtask
    // break bit shortened for run length, still above the slave threshold
    task automatic send_break(input int brk_cyc, input int bit_cyc);
        hold(1'b0, 13 * brk_cyc);
        hold(1'b1, bit_cyc);
    endtask
    task automatic send_header(input logic [7:0] pid, input int brk_cyc, input int bit_cyc);
        send_break(brk_cyc, bit_cyc);
        send_byte(8'h55, bit_cyc);
        send_byte(pid, bit_cyc);
        hold(1'b1, 2 * bit_cyc);
    endtask
endmodule

// ==== lshab_header_rx_tb_top.sv ====
// testbench for the lin slave header receiver
`timescale 1ns/1ps
module lshab_header_rx_tb_top;
    import lshab_pkg::*;
    // short break threshold, still above the longest low run in the test bytes
    localparam int BRK = 3000;
    // must outlast eight bits of the slowest synch byte used
    localparam int SYNC_TO = 10600;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic lin_rx, frame_start, sync_err, frame_err, period_valid, pid_valid, parity_err;
    lshab_cnt_t bit_period;
    logic [5:0] ident;
    logic [1:0] parity;
    lshab_class_t id_class;
    int error_cnt = 0;
    int n_checks = 0;
    int n_fs = 0;
    int n_se = 0;
    int n_fe = 0;
    logic [7:0] cap_pid;
    logic cap_perr;
    lshab_class_t cap_cls;
    always #20 mclk = ~mclk;
    lshab_header_rx #(.BREAK_CYCLES(BRK), .SYNC_TIMEOUT(SYNC_TO)) lshab_header_rx_inst (
        .mclk(mclk), .reset_n(reset_n), .lin_rx(lin_rx), .frame_start(frame_start),
        .sync_err(sync_err), .frame_err(frame_err), .bit_period(bit_period),
        .period_valid(period_valid), .pid_valid(pid_valid), .ident(ident), .parity(parity),
        .parity_err(parity_err), .id_class(id_class));
    lshab_lin_master lshab_lin_master_inst (.mclk(mclk), .lin_rx(lin_rx));
    // one-cycle strobes caught where they stand
    always @(posedge mclk) begin
        if (frame_start === 1'b1) n_fs++;
        if (sync_err === 1'b1) n_se++;
        if (frame_err === 1'b1) n_fe++;
        if (pid_valid === 1'b1) begin
            cap_pid = {parity, ident};
            cap_perr = parity_err;
            cap_cls = id_class;
        end
    end
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [1:0] par_of(input logic [5:0] id);
        return {~^{id[1], id[3], id[4], id[5]}, ^{id[0], id[1], id[2], id[4]}};
    endfunction
    function automatic lshab_class_t cls_of(input logic [5:0] id);
        if (id <= 6'h3B) return CLS_SIGNAL;
        if (id == 6'h3E) return CLS_USER;
        if (id == 6'h3F) return CLS_RSVD;
        return CLS_DIAG;
    endfunction
    // full header; flip corrupts chosen parity bits
    task automatic sc_header(input logic [5:0] id, input logic [1:0] flip, input int bit_cyc);
        int fs0;
        int se0;
        int fe0;
        logic [7:0] pid;
        fs0 = n_fs;
        se0 = n_se;
        fe0 = n_fe;
        pid = {par_of(id) ^ flip, id};
        lshab_lin_master_inst.send_header(pid, 240, bit_cyc);
        chk_val("frame starts", 20'(fs0 + 1), 20'(n_fs));
        chk_val("bit period", 20'(bit_cyc), bit_period);
        chk_bit("rate valid", 1'b1, period_valid);
        chk_val("identifier byte", 20'(pid), 20'(cap_pid));
        chk_bit("parity error", |flip, cap_perr);
        chk_val("class", 20'(cls_of(id)), 20'(cap_cls));
        chk_val("header synch errors", 20'(se0), 20'(n_se));
        chk_val("header frame errors", 20'(fe0), 20'(n_fe));
    endtask
    // break with no synch byte: header dropped after the timeout
    task automatic sc_timeout;
        int se0;
        se0 = n_se;
        lshab_lin_master_inst.send_break(240, 1250);
        repeat (SYNC_TO + 100) @(negedge mclk);
        chk_val("synch errors", 20'(se0 + 1), 20'(n_se));
        chk_bit("rate valid", 1'b0, period_valid);
    endtask
    // synch faster than the bus limit: rate refused, header dropped
    task automatic sc_fast_rate;
        int se0;
        se0 = n_se;
        lshab_lin_master_inst.send_break(240, 1000);
        lshab_lin_master_inst.send_byte(8'h55, 1000);
        chk_val("fast synch errors", 20'(se0 + 1), 20'(n_se));
        chk_bit("fast rate valid", 1'b0, period_valid);
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        sc_header(6'h3D, 2'b00, 1250);
        sc_header(6'h3E, 2'b01, 1300);
        sc_timeout();
        sc_fast_rate();
        end_of_test();
    end
    // about 94000 cycles expected
    initial begin
        repeat (98000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
endmodule
